/* File: two_button_setup_menu.sv */
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module two_button_setup_menu #(
    parameter int HOLD_CYCLES = two_button_setup_pkg::HOLD_CYCLES,
    parameter int DEBOUNCE_CYCLES = two_button_setup_pkg::DEBOUNCE_CYCLES,
    parameter int SLOW_STEP_CYCLES = two_button_setup_pkg::SLOW_STEP_CYCLES,
    parameter int FAST_STEP_CYCLES = two_button_setup_pkg::FAST_STEP_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // push buttons, high while pressed
    input wire logic buttonOne,
    input wire logic buttonTwo,
    // status led
    output logic statusLed,
    // nonvolatile storage
    input wire logic signed [3:0] nvOffsetIn,
    input wire logic signed [6:0] nvVerticalIn,
    input wire logic [1:0] nvExposureIn,
    output logic nvWrite,
    output logic signed [3:0] nvOffsetOut,
    output logic signed [6:0] nvVerticalOut,
    output logic [1:0] nvExposureOut,
    // applied settings and restart
    output logic signed [3:0] side_by_side_layout,
    output logic signed [6:0] verticalShift,
    output logic [1:0] exposure_control,
    output logic cameraRestart
);

    localparam int CW = 32;

    // reset release
    logic rstA_reg;
    logic rstN;
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstA_reg <= 1'b0;
            rstN <= 1'b0;
        end
        else
        begin
            rstA_reg <= 1'b1;
            rstN <= rstA_reg;
        end
    end

    logic [1:0] rawButton;
    logic [1:0] level;
    logic [1:0] longHeld;
    logic [1:0] shortRel;
    logic [1:0] longRel;
    logic lock_reg;
    assign rawButton = {buttonTwo, buttonOne};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_button
            logic syncA_reg, syncB_reg, level_reg, level_next, prev_reg, long_reg, long_next;
            logic [CW-1:0] bounce_reg, bounce_next, hold_reg, hold_next;
            always_comb
            begin
                level_next = level_reg;
                bounce_next = '0;
                if (syncB_reg != level_reg)
                begin
                    bounce_next = bounce_reg + 32'h1;
                    if (bounce_reg >= DEBOUNCE_CYCLES - 1)
                    begin
                        level_next = syncB_reg;
                        bounce_next = '0;
                    end
                end
                hold_next = '0;
                long_next = 1'b0;
                if (level_reg)
                begin
                    hold_next = long_reg ? hold_reg : hold_reg + 32'h1;
                    long_next = long_reg || (hold_reg >= HOLD_CYCLES - 1);
                end
            end
            always_ff @(posedge clock or negedge rstN)
            begin
                if (!rstN)
                begin
                    syncA_reg <= 1'b0;
                    syncB_reg <= 1'b0;
                    level_reg <= 1'b0;
                    prev_reg <= 1'b0;
                    long_reg <= 1'b0;
                    bounce_reg <= '0;
                    hold_reg <= '0;
                end
                else
                begin
                    syncA_reg <= rawButton[gi];
                    syncB_reg <= syncA_reg;
                    level_reg <= level_next;
                    prev_reg <= level_reg;
                    long_reg <= long_next;
                    bounce_reg <= bounce_next;
                    hold_reg <= hold_next;
                end
            end
            assign level[gi] = level_reg;
            assign longHeld[gi] = long_reg && !lock_reg;
            // events fire on release only
            assign shortRel[gi] = prev_reg && !level_reg && !long_reg && !lock_reg;
            assign longRel[gi] = prev_reg && !level_reg && long_reg && !lock_reg;
        end
    endgenerate

    // menu state
    two_button_setup_pkg::menu_e state_reg, state_next;
    logic calSel_reg, calSel_next;
    logic loaded_reg, loaded_next;
    logic signed [3:0] offWork_reg, offWork_next, offStore_reg, offStore_next;
    logic signed [6:0] vertWork_reg, vertWork_next, vertStore_reg, vertStore_next;
    logic [1:0] expWork_reg, expWork_next, expStore_reg, expStore_next;
    logic nvWrite_next, restart_next;
    logic abortReq;

    always_comb
    begin
        state_next = state_reg;
        calSel_next = calSel_reg;
        loaded_next = 1'b1;
        offWork_next = offWork_reg;
        vertWork_next = vertWork_reg;
        expWork_next = expWork_reg;
        offStore_next = offStore_reg;
        vertStore_next = vertStore_reg;
        expStore_next = expStore_reg;
        nvWrite_next = 1'b0;
        restart_next = 1'b0;
        if (!loaded_reg)
        begin
            offStore_next = nvOffsetIn;
            vertStore_next = nvVerticalIn;
            expStore_next = nvExposureIn;
        end
        else if (abortReq)
        begin
            state_next = two_button_setup_pkg::NORMAL;
        end
        else
        begin
            case (state_reg)
                two_button_setup_pkg::NORMAL:
                begin
                    if (longRel[0])
                    begin
                        state_next = two_button_setup_pkg::CAL_SELECT;
                        calSel_next = 1'b0;
                    end
                    else if (longRel[1])
                    begin
                        state_next = two_button_setup_pkg::EXPOSURE_SELECT;
                        expWork_next = expStore_reg;
                    end
                end
                two_button_setup_pkg::CAL_SELECT:
                begin
                    if (shortRel != 2'b00)
                        calSel_next = !calSel_reg;
                    else if (longRel[0])
                    begin
                        offWork_next = offStore_reg;
                        vertWork_next = vertStore_reg;
                        state_next = calSel_reg ? two_button_setup_pkg::OFFSET_ADJ
                            : two_button_setup_pkg::VERTICAL_ADJ;
                    end
                end
                two_button_setup_pkg::OFFSET_ADJ:
                begin
                    if (shortRel[0] && offWork_reg > -two_button_setup_pkg::OFFSET_LIMIT)
                        offWork_next = offWork_reg - 4'sd1;
                    else if (shortRel[1] && offWork_reg < two_button_setup_pkg::OFFSET_LIMIT)
                        offWork_next = offWork_reg + 4'sd1;
                    else if (longRel[0])
                    begin
                        offStore_next = offWork_reg;
                        nvWrite_next = 1'b1;
                        restart_next = 1'b1;
                        state_next = two_button_setup_pkg::NORMAL;
                    end
                end
                two_button_setup_pkg::VERTICAL_ADJ:
                begin
                    if (shortRel[0] && vertWork_reg > -two_button_setup_pkg::VERTICAL_LIMIT)
                        vertWork_next = vertWork_reg - 7'sd1;
                    else if (shortRel[1] && vertWork_reg < two_button_setup_pkg::VERTICAL_LIMIT)
                        vertWork_next = vertWork_reg + 7'sd1;
                    else if (longRel[0])
                    begin
                        vertStore_next = vertWork_reg;
                        nvWrite_next = 1'b1;
                        restart_next = 1'b1;
                        state_next = two_button_setup_pkg::NORMAL;
                    end
                end
                two_button_setup_pkg::EXPOSURE_SELECT:
                begin
                    if (shortRel[0])
                        expWork_next = expWork_reg + 2'h1;
                    else if (shortRel[1])
                        expWork_next = expWork_reg - 2'h1;
                    else if (longRel[1])
                    begin
                        expStore_next = expWork_reg;
                        nvWrite_next = 1'b1;
                        restart_next = 1'b1;
                        state_next = two_button_setup_pkg::NORMAL;
                    end
                end
                default:
                    state_next = two_button_setup_pkg::NORMAL;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            state_reg <= two_button_setup_pkg::NORMAL;
            calSel_reg <= 1'b0;
            loaded_reg <= 1'b0;
            offWork_reg <= '0;
            vertWork_reg <= '0;
            expWork_reg <= two_button_setup_pkg::EXPOSURE_DEFAULT;
            offStore_reg <= '0;
            vertStore_reg <= '0;
            expStore_reg <= two_button_setup_pkg::EXPOSURE_DEFAULT;
            nvWrite <= 1'b0;
            cameraRestart <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            calSel_reg <= calSel_next;
            loaded_reg <= loaded_next;
            offWork_reg <= offWork_next;
            vertWork_reg <= vertWork_next;
            expWork_reg <= expWork_next;
            offStore_reg <= offStore_next;
            vertStore_reg <= vertStore_next;
            expStore_reg <= expStore_next;
            nvWrite <= nvWrite_next;
            cameraRestart <= restart_next;
        end
    end

    assign nvOffsetOut = offStore_reg;
    assign nvVerticalOut = vertStore_reg;
    assign nvExposureOut = expStore_reg;
    assign side_by_side_layout = offStore_reg;
    assign verticalShift = vertStore_reg;
    assign exposure_control = expStore_reg;

    // led pattern: solid, fast blink, or n flashes, pause, repeat
    logic solid, fast;
    logic [2:0] flashes;
    always_comb
    begin
        solid = 1'b0;
        fast = 1'b0;
        flashes = 3'h1;
        case (state_reg)
            two_button_setup_pkg::NORMAL:
            begin
                solid = longHeld == 2'b00;
                fast = longHeld != 2'b00;
            end
            two_button_setup_pkg::CAL_SELECT:
            begin
                fast = longHeld[0];
                flashes = calSel_reg ? 3'h2 : 3'h1;
            end
            two_button_setup_pkg::VERTICAL_ADJ, two_button_setup_pkg::OFFSET_ADJ:
            begin
                solid = longHeld[0];
                fast = 1'b1;
            end
            two_button_setup_pkg::EXPOSURE_SELECT:
            begin
                solid = longHeld[1];
                flashes = {1'b0, expWork_reg} + 3'h1;
            end
            default:
                solid = 1'b1;
        endcase
    end

    logic [CW-1:0] tick_reg, tick_next;
    logic [3:0] step_reg, step_next;
    logic [3:0] stepLast;
    logic led_next;
    always_comb
    begin
        stepLast = fast ? 4'h1 : {flashes, 1'b0} + two_button_setup_pkg::PAUSE_STEPS - 4'h1;
        tick_next = tick_reg + 32'h1;
        step_next = step_reg;
        if (tick_reg >= (fast ? FAST_STEP_CYCLES : SLOW_STEP_CYCLES) - 1)
        begin
            tick_next = '0;
            step_next = (step_reg >= stepLast) ? 4'h0 : step_reg + 4'h1;
        end
        if (step_reg > stepLast)
            step_next = 4'h0;
        led_next = solid || (!step_reg[0] && step_reg < {flashes, 1'b0});
    end

    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            tick_reg <= '0;
            step_reg <= '0;
            statusLed <= 1'b0;
        end
        else
        begin
            tick_reg <= tick_next;
            step_reg <= step_next;
            statusLed <= led_next;
        end
    end

    // apb: read data latched in setup, write applied in access, one access cycle
    logic setupPhase, accessPhase, mapped;
    logic abort_reg, abort_next, lock_next, err_reg, err_next;
    logic [31:0] rdata_next, working, stored;
    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;
    assign mapped = paddr == two_button_setup_pkg::CTRL_OFFSET
        || paddr == two_button_setup_pkg::STATUS_OFFSET
        || paddr == two_button_setup_pkg::WORKING_OFFSET
        || paddr == two_button_setup_pkg::STORED_OFFSET;
    assign abortReq = abort_reg;
    assign pready = accessPhase;
    assign pslverr = accessPhase && err_reg;

    always_comb
    begin
        working = '0;
        working[two_button_setup_pkg::VALUE_OFFSET_POS +: 4] = offWork_reg;
        working[two_button_setup_pkg::VALUE_VERTICAL_POS +: 7] = vertWork_reg;
        working[two_button_setup_pkg::VALUE_EXPOSURE_POS +: 2] = expWork_reg;
        stored = '0;
        stored[two_button_setup_pkg::VALUE_OFFSET_POS +: 4] = offStore_reg;
        stored[two_button_setup_pkg::VALUE_VERTICAL_POS +: 7] = vertStore_reg;
        stored[two_button_setup_pkg::VALUE_EXPOSURE_POS +: 2] = expStore_reg;
        rdata_next = prdata;
        err_next = err_reg;
        lock_next = lock_reg;
        abort_next = 1'b0;
        if (setupPhase)
        begin
            err_next = !mapped;
            rdata_next = '0;
            case (paddr)
                two_button_setup_pkg::CTRL_OFFSET:
                    rdata_next[two_button_setup_pkg::CTRL_LOCK_BIT] = lock_reg;
                two_button_setup_pkg::STATUS_OFFSET:
                begin
                    rdata_next[two_button_setup_pkg::STATUS_STATE_POS +: 3] = state_reg;
                    rdata_next[two_button_setup_pkg::STATUS_CALSEL_BIT] = calSel_reg;
                    rdata_next[two_button_setup_pkg::STATUS_HOLD_BIT] = longHeld != 2'b00;
                    rdata_next[two_button_setup_pkg::STATUS_LED_BIT] = statusLed;
                end
                two_button_setup_pkg::WORKING_OFFSET:
                    rdata_next = working;
                two_button_setup_pkg::STORED_OFFSET:
                    rdata_next = stored;
                default:
                    rdata_next = '0;
            endcase
        end
        if (accessPhase && pwrite && paddr == two_button_setup_pkg::CTRL_OFFSET)
        begin
            lock_next = pwdata[two_button_setup_pkg::CTRL_LOCK_BIT];
            abort_next = pwdata[two_button_setup_pkg::CTRL_ABORT_BIT];
        end
    end

    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            prdata <= '0;
            err_reg <= 1'b0;
            lock_reg <= 1'b0;
            abort_reg <= 1'b0;
        end
        else
        begin
            prdata <= rdata_next;
            err_reg <= err_next;
            lock_reg <= lock_next;
            abort_reg <= abort_next;
        end
    end

endmodule : two_button_setup_menu
`default_nettype wire

/* File: two_button_setup_pkg.sv */
package two_button_setup_pkg;

    localparam int CLOCK_MHZ = 250;
    localparam int HOLD_TIME_MS = 1000;
    localparam int DEBOUNCE_TIME_MS = 10;
    localparam int SLOW_STEP_MS = 200;
    localparam int FAST_STEP_MS = 50;
    localparam int HOLD_CYCLES = HOLD_TIME_MS * 1000 * CLOCK_MHZ;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_MS * 1000 * CLOCK_MHZ;
    localparam int SLOW_STEP_CYCLES = SLOW_STEP_MS * 1000 * CLOCK_MHZ;
    localparam int FAST_STEP_CYCLES = FAST_STEP_MS * 1000 * CLOCK_MHZ;
    localparam logic [3:0] PAUSE_STEPS = 4'h4;

    localparam logic signed [3:0] OFFSET_LIMIT = 4'sd4;
    localparam logic signed [6:0] VERTICAL_LIMIT = 7'sd36;
    localparam logic [1:0] EXPOSURE_DEFAULT = 2'h0;
    localparam logic [1:0] EXPOSURE_LAST = 2'h3;

    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] WORKING_OFFSET = 8'h08;
    localparam logic [7:0] STORED_OFFSET = 8'h0c;

    localparam int CTRL_LOCK_BIT = 0;
    localparam int CTRL_ABORT_BIT = 1;
    localparam int STATUS_STATE_POS = 0;
    localparam int STATUS_CALSEL_BIT = 4;
    localparam int STATUS_HOLD_BIT = 5;
    localparam int STATUS_LED_BIT = 6;
    localparam int VALUE_OFFSET_POS = 0;
    localparam int VALUE_VERTICAL_POS = 8;
    localparam int VALUE_EXPOSURE_POS = 16;

    typedef enum logic [2:0] {
        NORMAL,
        CAL_SELECT,
        VERTICAL_ADJ,
        OFFSET_ADJ,
        EXPOSURE_SELECT
    } menu_e;

endpackage : two_button_setup_pkg

/* File: two_button_setup_menu_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module two_button_setup_menu_sva (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // bus side
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // menu side
    input wire logic statusLed,
    input wire logic nvWrite,
    input wire logic signed [3:0] nvOffsetOut,
    input wire logic [1:0] exposure_control,
    input wire logic cameraRestart
);
    logic [3:0] upCnt_reg;
    logic [3:0] upCnt_next;
    // cycles since reset release, saturating; masks the start-up load
    always_comb upCnt_next = (upCnt_reg == 4'hf) ? upCnt_reg : upCnt_reg + 4'h1;
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n) upCnt_reg <= 4'h0;
        else upCnt_reg <= upCnt_next;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    pready_access_a: assert property (pready == (psel && penable))
        else $error("pready differs from access phase");
    error_in_access_a: assert property (pslverr |-> pready)
        else $error("pslverr outside access phase");
    read_data_stands_a: assert property (pready |=> $stable(prdata))
        else $error("read data moved after access");
    led_reset_off_a: assert property ($rose(arst_n) |-> !statusLed)
        else $error("led lit while in reset");
    commit_pair_a: assert property (nvWrite == cameraRestart)
        else $error("store and restart not together");
    commit_pulse_a: assert property (nvWrite |=> !nvWrite)
        else $error("store pulse longer than one cycle");
    restart_pulse_a: assert property (cameraRestart |=> !cameraRestart)
        else $error("restart pulse longer than one cycle");
    offset_bound_a: assert property (nvWrite |-> (nvOffsetOut <= two_button_setup_pkg::OFFSET_LIMIT
        && nvOffsetOut >= -two_button_setup_pkg::OFFSET_LIMIT))
        else $error("stored offset out of range");
    exposure_hold_a: assert property ((upCnt_reg == 4'hf && $changed(exposure_control))
        |-> (nvWrite || $past(nvWrite)))
        else $error("exposure changed without commit");
endmodule : two_button_setup_menu_sva
bind two_button_setup_menu two_button_setup_menu_sva chk (.clock, .arst_n, .psel, .penable,
    .prdata, .pready, .pslverr, .statusLed, .nvWrite, .nvOffsetOut, .exposure_control,
    .cameraRestart);
`default_nettype wire

/* File: button_panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
module button_panel_model (
    // clock
    input wire logic clock,
    // buttons and led
    output logic buttonOne,
    output logic buttonTwo,
    input wire logic statusLed
);
    initial
    begin
        buttonOne = 1'b0;
        buttonTwo = 1'b0;
    end
    // press, hold for a count of cycles, release, then let the menu settle
    task automatic push(input logic second, input int hold);
        @(posedge clock);
        if (second) buttonTwo <= 1'b1;
        else buttonOne <= 1'b1;
        repeat (hold) @(posedge clock);
        buttonOne <= 1'b0;
        buttonTwo <= 1'b0;
        repeat (24) @(posedge clock);
    endtask : push
    // flashes of one pattern, framed by long dark gaps
    task automatic flashes(output int n);
        int dark;
        logic prev;
        dark = 0;
        n = 0;
        prev = 1'b0;
        while (dark < 20)
        begin
            @(posedge clock);
            dark = statusLed ? 0 : dark + 1;
        end
        dark = 0;
        while (dark < 20)
        begin
            @(posedge clock);
            if (statusLed && !prev) n++;
            prev = statusLed;
            // rest of the pause before the first flash is not a frame end
            dark = (statusLed || n == 0) ? 0 : dark + 1;
        end
    endtask : flashes
endmodule : button_panel_model
`default_nettype wire

/* File: two_button_setup_menu_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module two_button_setup_menu_tb_top;
    localparam int SHORT = 12;
    localparam int LONG = 60;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic buttonOne;
    logic buttonTwo;
    logic statusLed;
    logic signed [3:0] nvOff = 4'sh0;
    logic signed [6:0] nvVer = 7'sh0;
    logic [1:0] nvExp = 2'h0;
    logic nvWrite;
    logic signed [3:0] nvOffsetOut;
    logic signed [6:0] nvVerticalOut;
    logic [1:0] nvExposureOut;
    logic signed [3:0] side_by_side_layout;
    logic signed [6:0] verticalShift;
    logic [1:0] exposure_control;
    logic cameraRestart;
    logic [31:0] q;
    logic e;
    int errors = 0;
    int n_tests = 0;
    int commits = 0;
    int n;
    always #2 clock = ~clock;
    two_button_setup_menu #(.HOLD_CYCLES(40), .DEBOUNCE_CYCLES(4), .SLOW_STEP_CYCLES(8),
        .FAST_STEP_CYCLES(2)) dut (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .buttonOne, .buttonTwo, .statusLed, .nvOffsetIn(nvOff),
        .nvVerticalIn(nvVer), .nvExposureIn(nvExp), .nvWrite, .nvOffsetOut, .nvVerticalOut,
        .nvExposureOut, .side_by_side_layout, .verticalShift, .exposure_control, .cameraRestart);
    button_panel_model panel (.clock, .buttonOne, .buttonTwo, .statusLed);
    // nonvolatile store keeps what each commit writes
    always @(posedge clock)
    begin
        if (nvWrite === 1'b1)
        begin
            nvOff <= nvOffsetOut;
            nvVer <= nvVerticalOut;
            nvExp <= nvExposureOut;
            commits <= commits + 1;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 16);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rst();
        arst_n <= 1'b0;
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        repeat (10) @(posedge clock);
    endtask : rst
    task automatic t_reset();
        chk(32'(statusLed), 32'h1);
        chk(32'(exposure_control), 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        apb(1'b1, two_button_setup_pkg::STATUS_OFFSET, 32'h7);
        apb(1'b0, two_button_setup_pkg::STATUS_OFFSET, 32'h0);
        chk(32'(q[2:0]), 32'h0);
        $display("done reset");
    endtask : t_reset
    task automatic t_offset();
        panel.push(1'b0, LONG);
        apb(1'b0, two_button_setup_pkg::STATUS_OFFSET, 32'h0);
        chk(32'(q[2:0]), 32'h1);
        panel.flashes(n);
        chk(32'(n), 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            panel.push(i[0], SHORT);
            panel.flashes(n);
            chk(32'(n), 32'(2 - i[0]));
        end
        panel.push(1'b0, LONG);
        apb(1'b0, two_button_setup_pkg::STATUS_OFFSET, 32'h0);
        chk(32'(q[2:0]), 32'h3);
        fork
            panel.push(1'b0, 30);
            begin
                repeat (25) @(posedge clock);
                apb(1'b0, two_button_setup_pkg::WORKING_OFFSET, 32'h0);
                chk(32'(q[3:0]), 32'h0);
            end
        join
        repeat (5) panel.push(1'b0, SHORT);
        apb(1'b0, two_button_setup_pkg::WORKING_OFFSET, 32'h0);
        chk(32'(q[3:0]), 32'hc);
        repeat (9) panel.push(1'b1, SHORT);
        apb(1'b0, two_button_setup_pkg::WORKING_OFFSET, 32'h0);
        chk(32'(q[3:0]), 32'h4);
        panel.push(1'b0, LONG);
        chk(32'(commits), 32'h1);
        chk({28'h0, side_by_side_layout}, 32'h4);
        $display("done offset");
    endtask : t_offset
    task automatic t_exposure();
        panel.push(1'b1, LONG);
        apb(1'b0, two_button_setup_pkg::STATUS_OFFSET, 32'h0);
        chk(32'(q[2:0]), 32'h4);
        panel.flashes(n);
        chk(32'(n), 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            panel.push(i == 0, SHORT);
            panel.flashes(n);
            chk(32'(n), 32'((i + 3) % 4 + 1));
        end
        panel.push(1'b1, LONG);
        chk(32'(commits), 32'h2);
        chk(32'(exposure_control), 32'h2);
        $display("done exposure");
    endtask : t_exposure
    task automatic t_abort();
        panel.push(1'b1, LONG);
        panel.push(1'b0, SHORT);
        apb(1'b1, two_button_setup_pkg::CTRL_OFFSET, 32'h2);
        apb(1'b0, two_button_setup_pkg::STATUS_OFFSET, 32'h0);
        chk(32'(q[2:0]), 32'h0);
        chk(32'(exposure_control), 32'h2);
        apb(1'b1, two_button_setup_pkg::CTRL_OFFSET, 32'h1);
        apb(1'b0, two_button_setup_pkg::CTRL_OFFSET, 32'h0);
        chk(32'(q[0]), 32'h1);
        panel.push(1'b1, LONG);
        apb(1'b0, two_button_setup_pkg::STATUS_OFFSET, 32'h0);
        chk(32'(q[2:0]), 32'h0);
        apb(1'b1, two_button_setup_pkg::CTRL_OFFSET, 32'h0);
        panel.push(1'b0, LONG);
        panel.push(1'b0, LONG);
        panel.push(1'b1, SHORT);
        apb(1'b0, two_button_setup_pkg::WORKING_OFFSET, 32'h0);
        chk(32'(q[14:8]), 32'h1);
        rst();
        chk(32'(verticalShift), 32'h0);
        apb(1'b0, two_button_setup_pkg::STATUS_OFFSET, 32'h0);
        chk(32'(q[2:0]), 32'h0);
        chk({28'h0, side_by_side_layout}, 32'h4);
        chk(32'(exposure_control), 32'h2);
        $display("done abort");
    endtask : t_abort
    task automatic wrap_up();
        $display("tests=%0d errors=%0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (40000) @(posedge clock);
        errors++;
        wrap_up();
    end
    initial
    begin
        rst();
        t_reset();
        t_offset();
        t_exposure();
        t_abort();
        wrap_up();
    end
endmodule : two_button_setup_menu_tb_top
`default_nettype wire
